// File: rtl/card_feed_pkg.sv
// constants, state codes and window decoders for the card feed sequencer
// assumes one 20 MHz clock; positions arrive as index and tick pulses
// Overview of operation
// - punch run-in holds clutch for two cycles
// - then interlock set; punch feeds only on command
// - unrequested punch cycle drops control hold at 13.6
// - feed check lamp lit when control hold drops, until start key
// - misfeed latches feed stop, withdraws computer read control
// - feed stop latched blocks read control hold
// - feed stop ignores read start until hopper empty
// - empty hopper: read start runs cards out
// - restart deck: three run-ins, then computer control
// - hopper empty at 220 degrees stops read feed
// - start key after empty: cards run out uncalculated
// - end-of-file key gives three automatic feed cycles
// - after third, release latches, start key runs out
// - punch code selector picks from 13.8 to 9.8
// - transferred selector holds for rest of cycle
// - common impulse routed to transferred output
// - co-selector takes either pick, configured hold
// - punch co-selector picked, held 13.8 to 9.8
// - read co-selector picked, held 340 to 220 degrees
// - delayed pickup transfers one card cycle later
package card_feed_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_POS = 8'h0C;
   localparam logic [7:0] ADDR_SEL = 8'h10;
   // command and config fields
   localparam int CMD_PUNCH_BIT = 0;
   localparam int CMD_READ_BIT = 1;
   localparam int CFG_CO_LSB = 0;
   localparam int CFG_PILOT_LSB = 8;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // punch position in tenths of a cycle point
   localparam logic [7:0] PUNCH_POS_START = 8'h82;
   localparam logic [7:0] PUNCH_POS_MAX = 8'hB3;
   localparam logic [7:0] PUNCH_PT_13_6 = 8'h88;
   localparam logic [7:0] PUNCH_PT_13_8 = 8'h8A;
   localparam logic [7:0] PUNCH_PT_9_8 = 8'h62;
   // read position in degrees
   localparam logic [8:0] READ_POS_START = 9'h10E;
   localparam logic [8:0] READ_POS_MAX = 9'h167;
   localparam logic [8:0] READ_POS_LAST = 9'h10D;
   localparam logic [8:0] READ_DEG_340 = 9'h154;
   localparam logic [8:0] READ_DEG_220 = 9'h0DC;
   // cycle counts
   localparam logic [1:0] PUNCH_RUNIN_CYCLES = 2'h2;
   localparam logic [1:0] READ_RUNIN_CYCLES = 2'h3;
   localparam logic [1:0] EOF_CYCLES = 2'h3;

   typedef enum logic [3:0] {
      P_IDLE = 4'h1,
      P_RUNIN = 4'h2,
      P_COMPUTER = 4'h4,
      P_CHECK = 4'h8
   } punch_state_t;

   typedef enum logic [6:0] {
      R_IDLE = 7'h01,
      R_RUNIN = 7'h02,
      R_COMPUTER = 7'h04,
      R_MISFEED = 7'h08,
      R_EMPTY = 7'h10,
      R_EOF = 7'h20,
      R_RUNOUT = 7'h40
   } read_state_t;

   // window wraps through the end of the count
   function automatic logic punchWindow(input logic [7:0] pos);
      punchWindow = (pos >= PUNCH_PT_13_8) || (pos <= PUNCH_PT_9_8);
   endfunction : punchWindow

   function automatic logic readWindow(input logic [8:0] pos);
      readWindow = (pos >= READ_DEG_340) || (pos <= READ_DEG_220);
   endfunction : readWindow
endpackage : card_feed_pkg

// File: rtl/selector_cell.sv
// one selector: pick, delayed pick, hold and impulse routing
// assumes pick is already gated by the caller's window; clear is the caller's cycle start
module selector_cell (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pick and hold
   input wire logic pick,
   input wire logic pickLater,
   input wire logic advance,
   input wire logic clear,
   // routed impulse
   input wire logic common,
   output logic transferred,
   output logic normalOut,
   output logic xferOut
);
   logic pend_r;
   logic xfer_r;

   // delayed pick waits for the next card cycle; a new pick wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= pickLater | (pend_r & ~advance);
      end
   end

   // hold lasts until the hold circuit's cycle ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xfer_r <= 1'b0;
      end else begin
         xfer_r <= pick | (pend_r & advance) | (xfer_r & ~clear);
      end
   end

   // routing
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         normalOut <= 1'b0;
         xferOut <= 1'b0;
      end else begin
         normalOut <= common & ~xfer_r;
         xferOut <= common & xfer_r;
      end
   end

   assign transferred = xfer_r;

   property p_hold;
      @(posedge clk) disable iff (!rst_b) (xfer_r && !clear) |=> xfer_r;
   endproperty
   a_hold: assert property (p_hold) else $error("selector dropped early");

   property p_late;
      @(posedge clk) disable iff (!rst_b) (pend_r && advance) |=> xfer_r;
   endproperty
   a_late: assert property (p_late) else $error("delayed pick lost");

   property p_route;
      @(posedge clk) disable iff (!rst_b) (common && xfer_r) |=> (xferOut && !normalOut);
   endproperty
   a_route: assert property (p_route) else $error("impulse misrouted");
endmodule : selector_cell

// File: rtl/card_feed_control_sequencer.sv
// card feed sequencer: punch and read feed control and selectors
// assumes mechanical pins are asynchronous; the computer is the APB master
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
module card_feed_control_sequencer
   import card_feed_pkg::*;
#(
   parameter int NUM_PCS = 4,
   parameter int NUM_CO = 4,
   parameter int NUM_PILOT = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // feed timing and keys
   input wire logic punchIndex,
   input wire logic punchTick,
   input wire logic readIndex,
   input wire logic readTick,
   input wire logic punchStartKey,
   input wire logic readStartKey,
   input wire logic endOfFileKey,
   input wire logic hopperEmpty,
   input wire logic cardMisfeed,
   // selector impulses
   input wire logic [NUM_PCS-1:0] punchImpulse,
   input wire logic [NUM_PCS-1:0] codeCommon,
   input wire logic [NUM_CO-1:0] coPunchImpulse,
   input wire logic [NUM_CO-1:0] coReadImpulse,
   input wire logic [NUM_CO-1:0] coCommon,
   input wire logic [NUM_PILOT-1:0] immediatePickup,
   input wire logic [NUM_PILOT-1:0] delayedPickupX,
   input wire logic [NUM_PILOT-1:0] delayedPickupDigit,
   input wire logic [NUM_PILOT-1:0] pilotCommon,
   // feed control
   output logic punchClutchControl,
   output logic punchCalculateInterlock,
   output logic punchControlHold,
   output logic feedCheckLamp,
   output logic readClutch,
   output logic readControl,
   output logic cardFeedStop,
   output logic endOfFileLatch,
   // selector outputs
   output logic [NUM_PCS-1:0] codeNormal,
   output logic [NUM_PCS-1:0] codeXfer,
   output logic [NUM_CO-1:0] coNormal,
   output logic [NUM_CO-1:0] coXfer,
   output logic [NUM_PILOT-1:0] pilotNormal,
   output logic [NUM_PILOT-1:0] pilotXfer
);
   localparam int CTL_W = 9;
   localparam int SW = CTL_W + 2 * NUM_PCS + 3 * NUM_CO + 4 * NUM_PILOT;

   if (NUM_PCS < 1 || NUM_PCS > 8 || NUM_CO < 1 || NUM_CO > 8 ||
       NUM_PILOT < 1 || NUM_PILOT > 8) begin : g_bad_size
      $error("selector counts must lie in 1..8");
   end

   // two-stage synchroniser for every pin
   logic [SW-1:0] pinRaw;
   logic [SW-1:0] syncA_r;
   logic [SW-1:0] syncB_r;
   logic [CTL_W-1:0] prev_r;
   logic [CTL_W-1:0] rise;

   assign pinRaw = {pilotCommon, delayedPickupDigit, delayedPickupX, immediatePickup,
                    coCommon, coReadImpulse, coPunchImpulse, codeCommon, punchImpulse,
                    cardMisfeed, hopperEmpty, endOfFileKey, readStartKey, punchStartKey,
                    readTick, readIndex, punchTick, punchIndex};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA_r <= '0;
         syncB_r <= '0;
         prev_r <= '0;
      end else begin
         syncA_r <= pinRaw;
         syncB_r <= syncA_r;
         prev_r <= syncB_r[CTL_W-1:0];
      end
   end

   assign rise = syncB_r[CTL_W-1:0] & ~prev_r;

   logic pStart;
   logic pTick;
   logic rStart;
   logic rTick;
   logic pKeyRise;
   logic rKeyRise;
   logic rKeyLevel;
   logic eofRise;
   logic hopEmpty;
   logic misRise;
   logic [NUM_PCS-1:0] punchImpS;
   logic [NUM_PCS-1:0] codeCmS;
   logic [NUM_CO-1:0] coPunchS;
   logic [NUM_CO-1:0] coReadS;
   logic [NUM_CO-1:0] coCmS;
   logic [NUM_PILOT-1:0] immS;
   logic [NUM_PILOT-1:0] xS;
   logic [NUM_PILOT-1:0] dgS;
   logic [NUM_PILOT-1:0] pilCmS;

   assign {pilCmS, dgS, xS, immS, coCmS, coReadS, coPunchS, codeCmS, punchImpS} =
          syncB_r[SW-1:CTL_W];
   assign pStart = rise[0];
   assign pTick = rise[1];
   assign rStart = rise[2];
   assign rTick = rise[3];
   assign pKeyRise = rise[4];
   assign rKeyRise = rise[5];
   assign rKeyLevel = syncB_r[5];
   assign eofRise = rise[6];
   assign hopEmpty = syncB_r[7];
   assign misRise = rise[8];

   // per-cycle position counters, restarted by each feed cycle
   logic [7:0] punchPos_r;
   logic [8:0] readPos_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         punchPos_r <= PUNCH_POS_START;
      end else if (pStart) begin
         punchPos_r <= PUNCH_POS_START;
      end else if (pTick) begin
         punchPos_r <= (punchPos_r == PUNCH_POS_MAX) ? 8'h00 : punchPos_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readPos_r <= READ_POS_START;
      end else if (rStart) begin
         readPos_r <= READ_POS_START;
      end else if (rTick) begin
         readPos_r <= (readPos_r == READ_POS_MAX) ? 9'h000 : readPos_r + 9'h001;
      end
   end

   // apb slave: no wait states, registered answer
   logic apbSetup;
   logic apbWrite;
   logic cmdPunch;
   logic cmdRead;
   logic [7:0] cfgCo_r;
   logic [7:0] cfgPilot_r;
   logic punchPend_r;
   logic readPend_r;
   punch_state_t pState_r;
   read_state_t rState_r;
   logic [7:0] codeX8;
   logic [7:0] coX8;
   logic [7:0] pilotX8;
   logic [NUM_PCS-1:0] codeXferS;
   logic [NUM_CO-1:0] coXferS;
   logic [NUM_PILOT-1:0] pilotXferS;

   function automatic logic regHit(input logic [7:0] a);
      regHit = (a == ADDR_CMD) || (a == ADDR_CFG) || (a == ADDR_STAT) ||
               (a == ADDR_POS) || (a == ADDR_SEL);
   endfunction : regHit

   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pready & pwrite & regHit(paddr);
   assign cmdPunch = apbWrite && (paddr == ADDR_CMD) && pwdata[CMD_PUNCH_BIT];
   assign cmdRead = apbWrite && (paddr == ADDR_CMD) && pwdata[CMD_READ_BIT];
   assign codeX8 = 8'(codeXferS);
   assign coX8 = 8'(coXferS);
   assign pilotX8 = 8'(pilotXferS);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apbSetup;
         pslverr <= apbSetup & ~regHit(paddr);
         if (apbSetup && !pwrite) begin
            unique case (paddr)
               ADDR_CFG: prdata <= {16'h0000, cfgPilot_r, cfgCo_r};
               ADDR_STAT: prdata <= {9'h000, rState_r, 4'h0, pState_r,
                                     endOfFileLatch, cardFeedStop, readControl,
                                     feedCheckLamp, punchControlHold,
                                     punchCalculateInterlock, readPend_r, punchPend_r};
               ADDR_POS: prdata <= {7'h00, readPos_r, 8'h00, punchPos_r};
               ADDR_SEL: prdata <= {8'h00, pilotX8, coX8, codeX8};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfgCo_r <= CFG_RESET;
         cfgPilot_r <= CFG_RESET;
      end else if (apbWrite && paddr == ADDR_CFG) begin
         cfgCo_r <= pwdata[CFG_CO_LSB+:8];
         cfgPilot_r <= pwdata[CFG_PILOT_LSB+:8];
      end
   end

   // feed requests: a new command beats consumption in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         punchPend_r <= 1'b0;
         readPend_r <= 1'b0;
      end else begin
         punchPend_r <= (cmdPunch & punchCalculateInterlock) |
                        (punchPend_r & ~(pStart & punchClutchControl));
         readPend_r <= (cmdRead & readControl) |
                       (readPend_r & ~(rStart & readClutch));
      end
   end

   // punch feed sequence
   logic [1:0] pCnt_r;
   logic pUnreq_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pState_r <= P_IDLE;
         pCnt_r <= 2'h0;
         pUnreq_r <= 1'b0;
         punchClutchControl <= 1'b0;
         punchCalculateInterlock <= 1'b0;
         punchControlHold <= 1'b0;
         feedCheckLamp <= 1'b0;
      end else begin
         unique case (pState_r)
            P_IDLE, P_CHECK: begin
               if (pKeyRise) begin
                  pState_r <= P_RUNIN;
                  pCnt_r <= 2'h0;
                  punchClutchControl <= 1'b1;
                  feedCheckLamp <= 1'b0;
               end
            end
            P_RUNIN: begin
               if (pStart) begin
                  if (pCnt_r == PUNCH_RUNIN_CYCLES - 2'h1) begin
                     pState_r <= P_COMPUTER;
                     punchClutchControl <= 1'b0;
                     punchCalculateInterlock <= 1'b1;
                     punchControlHold <= 1'b1;
                     pUnreq_r <= 1'b0;
                  end else begin
                     pCnt_r <= pCnt_r + 2'h1;
                  end
               end
            end
            P_COMPUTER: begin
               punchClutchControl <= punchPend_r;
               if (pStart) begin
                  pUnreq_r <= ~punchClutchControl;
               end else if (pUnreq_r && punchPos_r == PUNCH_PT_13_6) begin
                  pState_r <= P_CHECK;
                  pUnreq_r <= 1'b0;
                  punchClutchControl <= 1'b0;
                  punchCalculateInterlock <= 1'b0;
                  punchControlHold <= 1'b0;
                  feedCheckLamp <= 1'b1;
               end
            end
            default: pState_r <= P_IDLE;
         endcase
      end
   end

   // read feed sequence
   logic [1:0] rCnt_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rState_r <= R_IDLE;
         rCnt_r <= 2'h0;
         readClutch <= 1'b0;
         readControl <= 1'b0;
         cardFeedStop <= 1'b0;
         endOfFileLatch <= 1'b0;
      end else begin
         unique case (rState_r)
            R_IDLE: begin
               if (rKeyRise && !hopEmpty) begin
                  rState_r <= R_RUNIN;
                  rCnt_r <= 2'h0;
                  readClutch <= 1'b1;
               end
            end
            R_RUNIN: begin
               if (rStart) begin
                  if (rCnt_r == READ_RUNIN_CYCLES - 2'h1) begin
                     rState_r <= R_COMPUTER;
                     readClutch <= 1'b0;
                     readControl <= 1'b1;
                  end else begin
                     rCnt_r <= rCnt_r + 2'h1;
                  end
               end
            end
            R_COMPUTER: begin
               readClutch <= readPend_r;
               if (misRise) begin
                  rState_r <= R_MISFEED;
                  cardFeedStop <= 1'b1;
                  readControl <= 1'b0;
                  readClutch <= 1'b0;
               end else if (hopEmpty && readPos_r == READ_DEG_220) begin
                  rState_r <= R_EMPTY;
                  readControl <= 1'b0;
                  readClutch <= 1'b0;
               end
            end
            R_MISFEED: begin
               // start key is dead while cards remain in the hopper
               if (hopEmpty && rKeyRise) begin
                  rState_r <= R_RUNOUT;
                  readClutch <= 1'b1;
               end
            end
            R_EMPTY: begin
               if (eofRise) begin
                  rState_r <= R_EOF;
                  rCnt_r <= 2'h0;
                  endOfFileLatch <= 1'b1;
                  readControl <= 1'b1;
                  readClutch <= 1'b1;
               end else if (rKeyRise) begin
                  rState_r <= R_RUNOUT;
                  readClutch <= 1'b1;
               end
            end
            R_EOF: begin
               if (rStart && rCnt_r != EOF_CYCLES) begin
                  rCnt_r <= rCnt_r + 2'h1;
                  if (rCnt_r == EOF_CYCLES - 2'h1) begin
                     readClutch <= 1'b0;
                  end
               end else if (rCnt_r == EOF_CYCLES && rTick && readPos_r == READ_POS_LAST) begin
                  // released at the end of the third cycle, standing in for the delay relay
                  rState_r <= R_RUNOUT;
                  endOfFileLatch <= 1'b0;
                  readControl <= 1'b0;
               end
            end
            R_RUNOUT: begin
               // cards already in the feed run out while the key is held
               if (rKeyRise && !hopEmpty) begin
                  rState_r <= R_RUNIN;
                  rCnt_r <= 2'h0;
                  cardFeedStop <= 1'b0;
                  readClutch <= 1'b1;
               end else begin
                  readClutch <= rKeyLevel;
               end
            end
            default: rState_r <= R_IDLE;
         endcase
      end
   end

   // selectors
   logic pWin;
   logic rWin;

   assign pWin = punchWindow(punchPos_r);
   assign rWin = readWindow(readPos_r);

   for (genvar i = 0; i < NUM_PCS; i++) begin : g_code
      selector_cell u_sel (
         .clk(clk),
         .rst_b(rst_b),
         .pick(punchImpS[i] & pWin),
         .pickLater(1'b0),
         .advance(1'b0),
         .clear(pStart),
         .common(codeCmS[i]),
         .transferred(codeXferS[i]),
         .normalOut(codeNormal[i]),
         .xferOut(codeXfer[i])
      );
   end

   for (genvar i = 0; i < NUM_CO; i++) begin : g_co
      selector_cell u_sel (
         .clk(clk),
         .rst_b(rst_b),
         .pick((coPunchS[i] | coReadS[i]) & (cfgCo_r[i] ? rWin : pWin)),
         .pickLater(1'b0),
         .advance(1'b0),
         .clear(cfgCo_r[i] ? rStart : pStart),
         .common(coCmS[i]),
         .transferred(coXferS[i]),
         .normalOut(coNormal[i]),
         .xferOut(coXfer[i])
      );
   end

   // delayed pickups ride the read cycle whatever hold is chosen
   for (genvar i = 0; i < NUM_PILOT; i++) begin : g_pilot
      selector_cell u_sel (
         .clk(clk),
         .rst_b(rst_b),
         .pick(immS[i] & (cfgPilot_r[i] ? rWin : pWin)),
         .pickLater(xS[i] | dgS[i]),
         .advance(rStart),
         .clear(cfgPilot_r[i] ? rStart : pStart),
         .common(pilCmS[i]),
         .transferred(pilotXferS[i]),
         .normalOut(pilotNormal[i]),
         .xferOut(pilotXfer[i])
      );
   end

   property p_runin_done;
      @(posedge clk) disable iff (!rst_b)
         $rose(punchCalculateInterlock) |-> $past(pState_r) == P_RUNIN && $past(pStart);
   endproperty
   a_runin_done: assert property (p_runin_done) else $error("interlock set early");

   property p_cmd_only;
      @(posedge clk) disable iff (!rst_b)
         (pState_r == P_COMPUTER && $rose(punchClutchControl)) |-> $past(punchPend_r);
   endproperty
   a_cmd_only: assert property (p_cmd_only) else $error("punch feed without command");

   property p_check_stop;
      @(posedge clk) disable iff (!rst_b)
         (pState_r == P_COMPUTER && pUnreq_r && !pStart && punchPos_r == PUNCH_PT_13_6)
         |=> !punchControlHold && !punchCalculateInterlock && feedCheckLamp;
   endproperty
   a_check_stop: assert property (p_check_stop) else $error("no feed check stop");

   property p_lamp;
      @(posedge clk) disable iff (!rst_b) (pState_r == P_CHECK) |-> feedCheckLamp;
   endproperty
   a_lamp: assert property (p_lamp) else $error("feed check lamp dark");

   property p_stop_blocks;
      @(posedge clk) disable iff (!rst_b) cardFeedStop |-> !readControl;
   endproperty
   a_stop_blocks: assert property (p_stop_blocks) else $error("read hold during stop");

   property p_key_dead;
      @(posedge clk) disable iff (!rst_b)
         (rState_r == R_MISFEED && !hopEmpty) |=> rState_r == R_MISFEED && !readClutch;
   endproperty
   a_key_dead: assert property (p_key_dead) else $error("start key not ignored");

   property p_empty_stop;
      @(posedge clk) disable iff (!rst_b)
         (rState_r == R_COMPUTER && !misRise && hopEmpty && readPos_r == READ_DEG_220)
         |=> !readControl && !readClutch;
   endproperty
   a_empty_stop: assert property (p_empty_stop) else $error("read not stopped");

   property p_eof;
      @(posedge clk) disable iff (!rst_b)
         (rState_r == R_EMPTY && eofRise) |=> endOfFileLatch && readControl && readClutch;
   endproperty
   a_eof: assert property (p_eof) else $error("end of file not latched");

   property p_pos_start;
      @(posedge clk) disable iff (!rst_b) pStart |=> punchPos_r == PUNCH_POS_START;
   endproperty
   a_pos_start: assert property (p_pos_start) else $error("punch position not restarted");
endmodule : card_feed_control_sequencer

// File: tb/computer_model.sv
// computer side: apb master issuing feed commands
// assumes clk from the bench, one transfer at a time
module computer_model (
   // apb master
   input wire logic clk,
   input wire logic pready,
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // feed requests are writes of the command word
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      // released address and data show inverted values, not stale ones; pwrite keeps its value
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
   endtask : xfer
endmodule : computer_model

// File: tb/tb_top.sv
// bench: apb reads checked against noted expectations
// assumes the computer model as master, 50 ns clock
module tb_top
   import card_feed_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, pready, pslverr, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, w;
   logic [31:0] seed = 32'h0000_C64D;
   logic [7:0] key = 8'h00;
   logic hop = 1'b0;
   logic [64:0] q[$];
   int failCount = 0, checks = 0;
   wire logic [3:0] punchImpulse, codeCommon, coPunchImpulse, coReadImpulse, coCommon;
   wire logic [3:0] immediatePickup, delayedPickupX, delayedPickupDigit, pilotCommon;
   logic [3:0] codeNormal, codeXfer, coNormal, coXfer, pilotNormal, pilotXfer;
   logic punchClutchControl, punchCalculateInterlock, punchControlHold, feedCheckLamp;
   logic readClutch, readControl, cardFeedStop, endOfFileLatch;
   wire logic punchStartKey = key[0], punchIndex = key[1], punchTick = key[2];
   wire logic readStartKey = key[3], readIndex = key[4], readTick = key[5];
   wire logic endOfFileKey = key[6], cardMisfeed = key[7], hopperEmpty = hop;
   // random impulses drive every selector impulse and common input
   assign {punchImpulse, codeCommon, coPunchImpulse, coReadImpulse, coCommon,
      immediatePickup, delayedPickupX, delayedPickupDigit, pilotCommon} = {seed, seed[3:0]};
   card_feed_control_sequencer DUT (.*);
   computer_model cpu (.*);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs
   always @(posedge clk) seed <= xs(seed);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
         checks++;
         if ({pslverr, prdata & q[0][63:32]} !== {q[0][64], q[0][31:0]}) begin
            failCount++;
            $display("mismatch t=%0t got=%h exp=%h", $time, {pslverr, prdata & q[0][63:32]},
                     {q[0][64], q[0][31:0]});
         end
         void'(q.pop_front());
      end
   end
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic x = 1'b0);
      q.push_back({x, m, e});
      cpu.xfer(1'b0, a, 32'h0000_0000);
   endtask : rd
   // pins pass two flops, so pulses are held several cycles
   task automatic pls(input int b, input int n);
      repeat (n) begin
         key[b] <= 1'b1;
         repeat (4) @(posedge clk);
         key[b] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : pls
   task automatic results;
      if (failCount == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      rst_b = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(ADDR_STAT, 32'h007F_0FFF, 32'h0001_0100);
      rd(ADDR_POS, 32'h01FF_00FF, 32'h010E_0082);
      rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      pls(0, 1);
      rd(ADDR_STAT, 32'h0000_0F04, 32'h0000_0200);
      pls(1, 2);
      rd(ADDR_STAT, 32'h0000_0F0C, 32'h0000_040C);
      cpu.xfer(1'b1, ADDR_CMD, 32'h0000_0001);
      pls(1, 1);
      pls(2, 8);
      rd(ADDR_STAT, 32'h0000_0F1C, 32'h0000_040C);
      // index with no command pending, then past 13.6
      pls(1, 1);
      pls(2, 8);
      rd(ADDR_STAT, 32'h0000_0F1C, 32'h0000_0810);
      w = seed;
      cpu.xfer(1'b1, ADDR_CFG, w);
      rd(ADDR_CFG, 32'h0000_0F0F, w & 32'h0000_0F0F);
      pls(3, 1);
      pls(4, 3);
      cpu.xfer(1'b1, ADDR_CMD, 32'h0000_0002);
      rd(ADDR_STAT, 32'h007F_00E2, 32'h0004_0022);
      pls(7, 1);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0008_0040);
      pls(3, 1);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0008_0040);
      hop <= 1'b1;
      pls(3, 1);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0040_0040);
      hop <= 1'b0;
      pls(3, 1);
      pls(4, 3);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0004_0020);
      // index leaves the count at 270 degrees; 310 ticks reach 220
      hop <= 1'b1;
      pls(5, 310);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0010_0000);
      pls(6, 1);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0020_00A0);
      pls(4, 3);
      pls(5, 360);
      rd(ADDR_STAT, 32'h007F_00E0, 32'h0040_0000);
      results();
   end
   initial begin
      #500000;
      failCount++;
      results();
   end
endmodule : tb_top
